//--- rtl/ssviu_regs.vh
`ifndef SSVIU_REGS_VH
`define SSVIU_REGS_VH
`define SSVIU_NUM_SRC      6
`define SSVIU_REQ_ADDR     8'hfa
`define SSVIU_REQ_RESET    6'h00
`define SSVIU_MASK_RESET   8'h00
`define SSVIU_PRIO_RESET   6'h00
`define SSVIU_MASK_GLOBAL  7
`define SSVIU_SRC_CMP2_F   0
`define SSVIU_SRC_REF_F    1
`define SSVIU_SRC_CMP1_F   2
`define SSVIU_SRC_CMP2_R   3
`define SSVIU_SRC_TMR0     4
`define SSVIU_SRC_TMR1     5
`endif

//--- rtl/ssviu_top.v
// Functional notes
// - six maskable sources join priority resolution
// - pin edges and both timers raise requests
// - global and per-source enable mask bits
// - programmable priority picks one pending request
// - grant disables interrupts, saves state, vectors
// - vectors come from fixed program memory
// - vector byte pair forms 16-bit address
// - request order and vector pairs 0,1..10,11
// - request register at FA, cleared at reset
`timescale 1ns/10ps
`default_nettype none
`include "ssviu_regs.vh"
module ssviu_top #(
  parameter NSRC = `SSVIU_NUM_SRC
) (
  // clock and reset
  input  wire            i_clock,
  input  wire            i_srst,
  // pins and timers
  input  wire            i_comparator_one_pin,
  input  wire            i_comparator_two_pin,
  input  wire            i_reference_pin,
  input  wire            i_timer_zero_end,
  input  wire            i_timer_one_end,
  // core register access
  input  wire            i_mask_we,
  input  wire [7:0]      i_mask_wdata,
  input  wire            i_prio_we,
  input  wire [5:0]      i_prio_wdata,
  input  wire            i_req_we,
  input  wire [5:0]      i_req_wdata,
  // core handshake
  input  wire            i_cycle_done,
  // outputs
  output reg  [5:0]      o_request,
  output reg  [7:0]      o_enable_mask,
  output reg  [5:0]      o_priority_select,
  output reg             o_grant,
  output reg  [2:0]      o_grant_id,
  output reg  [7:0]      o_vector_addr,
  output reg             o_busy
);
  // interrupt machine states
  localparam ST_IDLE = 3'h0;
  localparam ST_SAVE = 3'h1;
  localparam ST_VEC  = 3'h2;
  localparam ST_WAIT = 3'h3;

  // three-stage pin synchronisers; only stages 2 and 3 are compared
  reg  [2:0] sync1_q;
  reg  [2:0] sync2_q;
  reg  [2:0] sync3_q;
  // accepted pin levels, updated once stages 2 and 3 agree
  reg  [2:0] stable_q;
  // interrupt machine
  reg  [2:0] state_q;
  reg  [2:0] st_d;
  // request, mask and grant decode
  reg  [5:0] ev;
  reg  [5:0] pend;
  reg  [2:0] win;
  reg        found;
  reg        better;
  reg        grant_now;
  reg  [5:0] req_d;
  reg  [7:0] mask_d;
  integer    k;

  // pins ordered {reference, comparator_two, comparator_one}
  wire [2:0] pins;
  wire [2:0] agree;
  wire [2:0] fall;
  wire [2:0] rise;

  assign pins  = {i_reference_pin, i_comparator_two_pin, i_comparator_one_pin};
  assign agree = ~(sync2_q ^ sync3_q);
  assign fall  = stable_q & ~sync3_q & agree;
  assign rise  = ~stable_q & sync3_q & agree;

  // rank of a source under the priority select: lower wins
  function [2:0] rank;
    input [2:0] src;
    input [5:0] p;
    reg   [3:0] sum;
    reg   [3:0] rem;
    begin
      // four bits wide so the rotation cannot wrap before the modulo
      sum  = {1'b0, src} + {1'b0, p[2:0]};
      rem  = sum % 4'd6;
      rank = rem[2:0];
      // the swap may tie two sources; the lower index then wins
      if (p[3] && src[0])
        rank = rank ^ 3'h1;
    end
  endfunction

  // one-hot request bit of a source number
  function [5:0] src_bit;
    input [2:0] src;
    begin
      src_bit = 6'h01 << src;
    end
  endfunction

  // one request per source; pin edges from the synchronisers, timer ends direct
  always @* begin
    ev = 6'h00;
    ev[`SSVIU_SRC_CMP2_F] = fall[1];
    ev[`SSVIU_SRC_REF_F]  = fall[2];
    ev[`SSVIU_SRC_CMP1_F] = fall[0];
    ev[`SSVIU_SRC_CMP2_R] = rise[1];
    ev[`SSVIU_SRC_TMR0]   = i_timer_zero_end;
    ev[`SSVIU_SRC_TMR1]   = i_timer_one_end;
  end

  // masked requests and priority resolution
  always @* begin
    pend   = o_request & o_enable_mask[5:0];
    pend   = pend & {6{o_enable_mask[`SSVIU_MASK_GLOBAL]}};
    found  = 1'b0;
    win    = 3'h0;
    better = 1'b0;
    // strict compare keeps the lower index on equal rank
    for (k = 0; k < NSRC; k = k + 1) begin
      better = !found || (rank(k[2:0], o_priority_select) < rank(win, o_priority_select));
      if (pend[k] && better) begin
        found = 1'b1;
        win   = k[2:0];
      end
    end
    // only an idle machine may grant: one grant per interrupt cycle
    grant_now = found && (state_q == ST_IDLE);
  end

  // interrupt machine: save, vector fetch, then wait for the core
  always @* begin
    st_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (grant_now)
          st_d = ST_SAVE;
      end
      ST_SAVE: begin
        st_d = ST_VEC;
      end
      ST_VEC: begin
        st_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (i_cycle_done)
          st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // a software write loads the register and a grant clears its bit, but a new event always wins
  always @* begin
    req_d = o_request;
    if (i_req_we)
      req_d = i_req_wdata;
    if (grant_now)
      req_d = req_d & ~src_bit(win);
    // bits latch whatever the mask, so polled software still sees them
    req_d = req_d | ev;
  end

  // the grant clears the global enable even against a same-cycle write,
  // so a stale write cannot reopen interrupts inside the machine cycle
  always @* begin
    mask_d = o_enable_mask;
    if (i_mask_we)
      mask_d = i_mask_wdata; // software re-enables
    if (grant_now)
      mask_d[`SSVIU_MASK_GLOBAL] = 1'b0;
  end

  always @(posedge i_clock) begin
    if (i_srst) begin
      // idle-high reset level: no false falling edge after reset
      sync1_q  <= 3'h7;
      sync2_q  <= 3'h7;
      sync3_q  <= 3'h7;
      stable_q <= 3'h7;
    end else begin
      sync1_q  <= pins;
      sync2_q  <= sync1_q;
      sync3_q  <= sync2_q;
      stable_q <= (stable_q & ~agree) | (sync3_q & agree);
    end
  end

  always @(posedge i_clock) begin
    if (i_srst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= st_d;
    end
  end

  // software-visible request, mask and priority registers
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_request         <= `SSVIU_REQ_RESET;
      o_enable_mask     <= `SSVIU_MASK_RESET;
      o_priority_select <= `SSVIU_PRIO_RESET;
    end else begin
      o_request     <= req_d;
      o_enable_mask <= mask_d;
      if (i_prio_we)
        o_priority_select <= i_prio_wdata;
    end
  end

  // grant pulse, source number and vector byte address
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_grant       <= 1'b0;
      o_grant_id    <= 3'h0;
      o_vector_addr <= 8'h00;
    end else begin
      o_grant <= grant_now; // single grant per cycle
      if (grant_now) begin
        o_grant_id    <= win;
        // high byte of the start address at 2n, low byte at 2n+1
        o_vector_addr <= {4'h0, win, 1'b0};
      end
    end
  end

  // busy spans the whole machine cycle, until the core reports completion
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_busy <= 1'b0;
    end else if (grant_now) begin
      o_busy <= 1'b1;
    end else if (state_q == ST_WAIT && i_cycle_done) begin
      o_busy <= 1'b0;
    end
  end

endmodule // ssviu_top
`default_nettype wire

//--- verif/ssviu_properties.sv
`timescale 1ns/10ps
`default_nettype none
module ssviu_chk(input wire i_clock, i_srst, i_timer_zero_end, i_cycle_done, o_grant, o_busy,
  input wire [7:0] o_enable_mask, o_vector_addr, input wire [5:0] o_request,
  input wire [2:0] o_grant_id);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  sequence s_done; o_busy && i_cycle_done; endsequence
  grant_pulse_a: assert property (o_grant |=> !o_grant) else $error("grant too long");
  grant_global_a: assert property (o_grant |-> $past(o_enable_mask[7])) else $error("masked");
  grant_blocks_a: assert property (o_grant |-> !o_enable_mask[7] && o_busy) else $error("blk");
  vector_pair_a: assert property (
    o_grant |-> o_vector_addr == {4'h0, o_grant_id, 1'b0}) else $error("vector");
  grant_pending_a: assert property (o_grant |->
    (($past(o_request & o_enable_mask[5:0]) >> o_grant_id) & 6'h01) != 6'h00)
    else $error("not pending");
  busy_release_a: assert property (s_done |=> !o_busy) else $error("busy stuck");
  busy_cause_a: assert property ($fell(o_busy) |-> $past(i_cycle_done)) else $error("drop");
  timer_latch_a: assert property (i_timer_zero_end |=> o_request[4]) else $error("lost");
endmodule // ssviu_chk
bind ssviu_top ssviu_chk chk (
  .i_clock(i_clock), .i_srst(i_srst), .i_timer_zero_end(i_timer_zero_end),
  .i_cycle_done(i_cycle_done), .o_grant(o_grant), .o_busy(o_busy),
  .o_enable_mask(o_enable_mask), .o_vector_addr(o_vector_addr),
  .o_request(o_request), .o_grant_id(o_grant_id));
`default_nettype wire

//--- verif/ssviu_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module ssviu_core(input wire i_clock, input wire i_grant, output wire o_done);
  reg [2:0] dly_q = 3'h0;
  // save and fixed vector fetch take three cycles, no vector driven on a bus
  always @(posedge i_clock) dly_q <= {dly_q[1:0], i_grant};
  assign o_done = dly_q[2];
endmodule // ssviu_core
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam [47:0] ROWS = 48'h55_4c_42_c1_e3_a0; // {c1,c2,ref}, {t1,t0}, id
  reg clk = 0, srst = 1, c1 = 1, c2 = 1, rf = 1, t0 = 0, t1 = 0, mwe = 0;
  reg [7:0] mw = 8'h00;
  reg pwe = 0, qwe = 0;
  reg [5:0] pw = 6'h00, qw = 6'h00;
  wire done, g, b;
  wire [2:0] id;
  wire [5:0] rq, ps;
  wire [7:0] va, em;
  integer bad_count = 0, n_compared = 0, i, k;
  ssviu_top uut(.i_clock(clk), .i_srst(srst), .i_comparator_one_pin(c1),
    .i_comparator_two_pin(c2), .i_reference_pin(rf), .i_timer_zero_end(t0),
    .i_timer_one_end(t1), .i_mask_we(mwe), .i_mask_wdata(mw), .i_prio_we(pwe),
    .i_prio_wdata(pw), .i_req_we(qwe), .i_req_wdata(qw), .i_cycle_done(done),
    .o_request(rq), .o_enable_mask(em), .o_priority_select(ps), .o_grant(g), .o_grant_id(id),
    .o_vector_addr(va), .o_busy(b));
  ssviu_core core(.i_clock(clk), .i_grant(g), .o_done(done));
  initial forever #5 clk = ~clk;
  task chk(input [63:0] nm, input [7:0] e, input [7:0] s); begin
    n_compared = n_compared + 1;
    if (e !== s) begin
      bad_count = bad_count + 1;
      $display("BAD %0s exp %h got %h", nm, e, s);
    end
  end endtask
  task wrap_up; begin
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  end endtask
  task fire(input [7:0] r, input [7:0] m); begin
    @(posedge clk);
    mwe <= 1'b1; mw <= m; {c1, c2, rf} <= r[7:5]; {t1, t0} <= r[4:3];
    @(posedge clk);
    mwe <= 1'b0; {t1, t0} <= 2'b00;
    for (k = 0; k < 12 && g !== 1'b1; k = k + 1) @(negedge clk);
  end endtask
  // about sixteen times the expected run length
  initial begin #20000 bad_count = bad_count + 1; wrap_up; end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      fire(ROWS[i*8+:8], 8'hbf);
      chk("grant", 8'h01, {7'h0, g});
      chk("id", {5'h0, ROWS[i*8+:3]}, {5'h0, id});
      chk("vector", {4'h0, ROWS[i*8+:3], 1'b0}, va);
      repeat (6) @(negedge clk);
      chk("busy", 8'h00, {7'h0, b});
      $display("row %0d done", i);
    end
    @(posedge clk);
    pwe <= 1'b1;
    pw <= 6'h01;
    @(posedge clk);
    pwe <= 1'b0;
    fire(8'h5d, 8'hbf); // both timers at once; rotation 1 ranks timer one first
    chk("id", 8'h05, {5'h0, id});
    chk("vector", 8'h0a, va);
    chk("mask", 8'h3f, em);
    chk("request", 8'h10, {2'h0, rq});
    chk("prio", 8'h01, {2'h0, ps});
    repeat (6) @(negedge clk);
    chk("held", 8'h00, {7'h0, g});
    chk("pending", 8'h10, {2'h0, rq});
    fire(8'h44, 8'hbf); // re-enable: the waiting timer zero is granted now
    chk("grant", 8'h01, {7'h0, g});
    chk("id", 8'h04, {5'h0, id});
    chk("vector", 8'h08, va);
    repeat (6) @(negedge clk);
    chk("busy", 8'h00, {7'h0, b});
    $display("priority done");
    fire(8'h50, 8'h3f); // polled: global off, timer one pulses
    chk("grant", 8'h00, {7'h0, g});
    chk("request", 8'h20, {2'h0, rq});
    $display("polled done");
    @(posedge clk);
    qwe <= 1'b1;
    qw <= 6'h00;
    t0 <= 1'b1;
    @(posedge clk);
    qwe <= 1'b0;
    t0 <= 1'b0;
    @(negedge clk);
    chk("set_wins", 8'h10, {2'h0, rq});
    @(posedge clk);
    qwe <= 1'b1;
    @(posedge clk);
    qwe <= 1'b0;
    @(negedge clk);
    chk("cleared", 8'h00, {2'h0, rq});
    $display("clear done");
    @(posedge clk) srst <= 1'b1;
    repeat (2) @(negedge clk);
    chk("reset", 8'h00, {2'h0, rq});
    $display("reset done");
    wrap_up;
  end
endmodule // tb
`default_nettype wire
